// ### hw/gpr_freeze.sv
// Configuration freeze key sequencer
`timescale 1ns/1ps
module gpr_freeze
  import gpr_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                srst_i,
  // Write strobe and data: bit 16 key, bits 15:0 per-pin freeze
  input  wire logic                freeze_wr_i,
  input  wire logic [16:0]         freeze_wdata_i,
  // State
  output logic      [PIN_N-1:0]    frozen_mask_o,
  output logic      [16:0]         freeze_rdata_o
);

  gpr_frz_state_t   state_reg;
  gpr_frz_state_t   state_next;
  logic [PIN_N-1:0] bits_reg;
  logic [PIN_N-1:0] bits_next;
  logic             key;
  logic             same;

  assign key  = freeze_wdata_i[FREEZE_KEY_POS];
  assign same = (freeze_wdata_i[PIN_N-1:0] == bits_reg);

  // Key must go 1, 0, 1 with identical pin bits; any slip restarts
  always_comb begin
    state_next = state_reg;
    bits_next  = bits_reg;
    if (freeze_wr_i && state_reg != FRZ_DONE) begin
      bits_next = freeze_wdata_i[PIN_N-1:0];
      case (state_reg)
        FRZ_IDLE: state_next = key ? FRZ_KEY1 : FRZ_IDLE;
        FRZ_KEY1: state_next = (!key && same) ? FRZ_KEY0 : (key ? FRZ_KEY1 : FRZ_IDLE);
        FRZ_KEY0: state_next = (key && same) ? FRZ_DONE : FRZ_IDLE;
        default:  state_next = FRZ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= FRZ_IDLE;
      bits_reg  <= '0;
    end else begin
      state_reg <= state_next;
      bits_reg  <= bits_next;
    end
  end

  // Held until reset: only srst_i leaves FRZ_DONE
  assign frozen_mask_o  = (state_reg == FRZ_DONE) ? bits_reg : '0;
  assign freeze_rdata_o = {state_reg == FRZ_DONE, bits_reg};

endmodule

// ### hw/gpr_pkg.sv
// Shared constants and types for the general-purpose port with remap unit
package gpr_pkg;

  localparam int          PIN_N          = 16;
  localparam int          PORT_N         = 5;
  localparam int          SLOT_W         = 4;

  // Reset values
  localparam logic [31:0] CFG_RST        = 32'h4444_4444;
  localparam logic [15:0] OUT_RST        = 16'h0000;
  localparam logic [31:0] REMAP_RST      = 32'h0000_0000;
  localparam logic [63:0] LSS_RST        = 64'h0000_0000_0000_0000;

  // Direction/speed field codes (low two bits of a pin slot)
  localparam logic [1:0]  DIR_INPUT      = 2'h0;
  localparam logic [1:0]  DIR_OUT_10M    = 2'h1;
  localparam logic [1:0]  DIR_OUT_2M     = 2'h2;
  localparam logic [1:0]  DIR_OUT_50M    = 2'h3;

  // Function field codes (high two bits of a pin slot)
  localparam logic [1:0]  FN_ANALOG      = 2'h0;
  localparam logic [1:0]  FN_FLOAT       = 2'h1;
  localparam logic [1:0]  FN_PULLED      = 2'h2;
  localparam logic [1:0]  FN_PORT_PP     = 2'h0;
  localparam logic [1:0]  FN_PORT_OD     = 2'h1;
  localparam logic [1:0]  FN_PERIPH_PP   = 2'h2;
  localparam logic [1:0]  FN_PERIPH_OD   = 2'h3;

  // Field positions
  localparam int          DIR_LSB        = 0;
  localparam int          FN_LSB         = 2;
  localparam int          BSC_CLR_LSB    = 16;
  localparam int          FREEZE_KEY_POS = 16;
  localparam int          DBG_REL_LSB    = 24;

  // Debug pin release codes
  localparam logic [2:0]  REL_KEEP_ALL   = 3'h0;
  localparam logic [2:0]  REL_FREE_RST   = 3'h1;
  localparam logic [2:0]  REL_FREE_ALL   = 3'h4;

  // Port indices and debug pin positions
  localparam logic [2:0]  PORT_A         = 3'h0;
  localparam logic [2:0]  PORT_B         = 3'h1;
  localparam int          DBG_MODE_PIN   = 13;
  localparam int          DBG_CLK_PIN    = 14;
  localparam int          DBG_DIN_PIN    = 15;
  localparam int          DBG_DOUT_PIN   = 3;
  localparam int          DBG_RST_PIN    = 4;

  typedef enum logic [1:0] {
    FRZ_IDLE,
    FRZ_KEY1,
    FRZ_KEY0,
    FRZ_DONE
  } gpr_frz_state_t;

endpackage

// ### hw/gpr_port.sv
// General-purpose 16-pin port with freeze, atomic set/clear and remap unit
//
// How it works
// - Each pin has eight modes chosen by function and direction fields.
// - Direction 00 is input; 01, 10, 11 are outputs of 10, 2, 50 MHz.
// - Output with function 00 is port push-pull, 01 port open-drain.
// - Output with function 10 is peripheral push-pull, 11 peripheral open-drain.
// - Input pins feed their sampled level to peripherals.
// - Reset leaves peripheral functions off and non-debug pins floating inputs without pulls.
// - Debug pins after reset: data-in, mode, reset pull up; clock down; data-out float.
// - Pin levels are sampled every clock; the input state takes a level once two successive samples agree.
// - Port-driven outputs follow the output value register.
// - A set/clear write touches only bits written as one.
// - Open-drain: zero drives low, one releases the pin.
// - Push-pull: zero drives low, one drives high.
// - Output value reads back as written; input state shows the pin.
// - Outputs have no pulls; inputs have no output driver but keep input path.
// - Analog pins: no pulls, driver or input path; state bit reads zero.
// - Peripheral outputs are driven by the peripheral, not the output register.
// - After the freeze key sequence, frozen pins ignore configuration writes till reset.
// - Remap registers let peripherals move to alternative pin locations.
// - Source select registers pick the port feeding each external line.
// - A 3-bit release field frees debug pins for general use.
// - Release 000 keeps all, 001 frees reset pin, 100 frees all; others forbidden.
// - Both configuration registers reset to floating input in every slot.
// - External line x comes from pin x of the selected port.
`timescale 1ns/1ps
module gpr_port
  import gpr_pkg::*;
#(
  parameter logic [2:0] PORT_IDX = PORT_A
)(
  // Clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    srst_i,
  // Configuration writes
  input  wire logic                    cfg_low_wr_i,
  input  wire logic                    cfg_high_wr_i,
  input  wire logic [31:0]             cfg_wdata_i,
  // Output value writes
  input  wire logic                    out_wr_i,
  input  wire logic [15:0]             out_wdata_i,
  input  wire logic                    bsc_wr_i,
  input  wire logic [31:0]             bsc_wdata_i,
  input  wire logic                    bc_wr_i,
  input  wire logic [15:0]             bc_wdata_i,
  // Freeze writes
  input  wire logic                    freeze_wr_i,
  input  wire logic [16:0]             freeze_wdata_i,
  // Remap unit writes
  input  wire logic                    remap0_wr_i,
  input  wire logic                    remap1_wr_i,
  input  wire logic [31:0]             remap_wdata_i,
  input  wire logic [3:0]              lss_wr_i,
  input  wire logic [15:0]             lss_wdata_i,
  input  wire logic [PORT_N*PIN_N-1:0] other_port_level_i,
  // Pads
  input  wire logic [PIN_N-1:0]        pad_in_i,
  output logic      [PIN_N-1:0]        pad_out_o,
  output logic      [PIN_N-1:0]        pad_oe_o,
  output logic      [PIN_N-1:0]        pad_pull_up_o,
  output logic      [PIN_N-1:0]        pad_pull_dn_o,
  output logic      [PIN_N-1:0]        pad_in_en_o,
  output logic      [2*PIN_N-1:0]      pad_speed_o,
  // Peripheral side
  input  wire logic [PIN_N-1:0]        periph_out_i,
  output logic      [PIN_N-1:0]        periph_in_o,
  // Readback and status
  output logic      [31:0]             pin_config_low_o,
  output logic      [31:0]             pin_config_high_o,
  output logic      [15:0]             pin_output_value_o,
  output logic      [15:0]             pin_input_state_o,
  output logic      [16:0]             config_freeze_reg_o,
  output logic      [31:0]             remap_config_0_o,
  output logic      [31:0]             remap_config_1_o,
  output logic      [63:0]             line_source_select_o,
  output logic      [PIN_N-1:0]        ext_line_o
);

  // ****************************************************************
  // Configuration and output value registers
  // ****************************************************************
  logic [31:0]      cfg_low_reg, cfg_low_next, cfg_high_reg, cfg_high_next;
  logic [15:0]      out_reg, out_next;
  logic [PIN_N-1:0] frozen_mask;
  logic [63:0]      slot_lock;
  logic [63:0]      cfg_all;

  for (genvar p = 0; p < PIN_N; p++) begin : g_lockx
    assign slot_lock[4*p +: 4] = {4{frozen_mask[p]}};
  end

  always_comb begin
    // Frozen slots keep their old value whatever is written
    cfg_low_next  = cfg_low_reg;
    cfg_high_next = cfg_high_reg;
    if (cfg_low_wr_i) begin
      cfg_low_next = (cfg_low_reg & slot_lock[31:0])
                   | (cfg_wdata_i & ~slot_lock[31:0]);
    end
    if (cfg_high_wr_i) begin
      cfg_high_next = (cfg_high_reg & slot_lock[63:32])
                    | (cfg_wdata_i & ~slot_lock[63:32]);
    end
  end

  always_comb begin
    // Set wins over clear within one set/clear write
    out_next = out_reg;
    if (out_wr_i) begin
      out_next = out_wdata_i;
    end
    if (bsc_wr_i) begin
      out_next = (out_next & ~bsc_wdata_i[BSC_CLR_LSB +: 16]) | bsc_wdata_i[15:0];
    end
    if (bc_wr_i) begin
      out_next = out_next & ~bc_wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg_low_reg  <= CFG_RST;
      cfg_high_reg <= CFG_RST;
      out_reg      <= OUT_RST;
    end else begin
      cfg_low_reg  <= cfg_low_next;
      cfg_high_reg <= cfg_high_next;
      out_reg      <= out_next;
    end
  end

  assign cfg_all = {cfg_high_reg, cfg_low_reg};

  gpr_freeze u_freeze (
    .clk_i          (clk_i),
    .srst_i         (srst_i),
    .freeze_wr_i    (freeze_wr_i),
    .freeze_wdata_i (freeze_wdata_i),
    .frozen_mask_o  (frozen_mask),
    .freeze_rdata_o (config_freeze_reg_o)
  );

  // ****************************************************************
  // Pin sampling
  // ****************************************************************
  logic [PIN_N-1:0] s1_reg, s2_reg, s3_reg, lvl_reg;
  logic [PIN_N-1:0] s1_next, s2_next, s3_next, lvl_next;
  logic [PIN_N-1:0] agree;

  always_comb begin
    s1_next  = pad_in_i;
    s2_next  = s1_reg;
    s3_next  = s2_reg;
    agree    = ~(s2_reg ^ s3_reg);
    lvl_next = (lvl_reg & ~agree) | (s3_reg & agree);
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1_reg  <= '0;
      s2_reg  <= '0;
      s3_reg  <= '0;
      lvl_reg <= '0;
    end else begin
      s1_reg  <= s1_next;
      s2_reg  <= s2_next;
      s3_reg  <= s3_next;
      lvl_reg <= lvl_next;
    end
  end

  // ****************************************************************
  // Debug pin ownership
  // ****************************************************************
  logic [2:0]       dbg_rel;
  logic [PIN_N-1:0] dbg_own, dbg_pu, dbg_pd;

  assign dbg_rel = remap_config_0_o[DBG_REL_LSB +: 3];

  always_comb begin
    // Forbidden release codes behave like keep-all, the safe choice
    dbg_own = '0;
    dbg_pu  = '0;
    dbg_pd  = '0;
    if (PORT_IDX == PORT_A && dbg_rel != REL_FREE_ALL) begin
      dbg_own[DBG_MODE_PIN] = 1'b1;
      dbg_own[DBG_CLK_PIN]  = 1'b1;
      dbg_own[DBG_DIN_PIN]  = 1'b1;
      dbg_pu[DBG_MODE_PIN]  = 1'b1;
      dbg_pd[DBG_CLK_PIN]   = 1'b1;
      dbg_pu[DBG_DIN_PIN]   = 1'b1;
    end else if (PORT_IDX == PORT_B && dbg_rel != REL_FREE_ALL) begin
      dbg_own[DBG_DOUT_PIN] = 1'b1;
      dbg_own[DBG_RST_PIN]  = (dbg_rel != REL_FREE_RST);
      dbg_pu[DBG_RST_PIN]   = (dbg_rel != REL_FREE_RST);
    end
  end

  // ****************************************************************
  // Per-pin mode decode and pad drive
  // ****************************************************************
  logic [PIN_N-1:0] is_out, is_analog, is_pulled, is_periph, is_od, drv;

  for (genvar p = 0; p < PIN_N; p++) begin : g_pin
    logic [1:0] dir, fn;
    assign dir          = cfg_all[4*p + DIR_LSB +: 2];
    assign fn           = cfg_all[4*p + FN_LSB +: 2];
    assign is_out[p]    = (dir != DIR_INPUT);
    assign is_analog[p] = !is_out[p] && fn == FN_ANALOG;
    assign is_pulled[p] = !is_out[p] && fn == FN_PULLED;
    assign is_periph[p] = is_out[p] && (fn == FN_PERIPH_PP || fn == FN_PERIPH_OD);
    assign is_od[p]     = is_out[p] && (fn == FN_PORT_OD || fn == FN_PERIPH_OD);
    assign drv[p]       = is_periph[p] ? periph_out_i[p] : out_reg[p];

    // Open-drain never drives high; a one only releases the pad
    assign pad_oe_o[p]      = !dbg_own[p] && is_out[p]
                              && !(is_od[p] && drv[p]);
    assign pad_out_o[p]     = drv[p] && !is_od[p];
    assign pad_pull_up_o[p] = dbg_own[p] ? dbg_pu[p] : (is_pulled[p] && out_reg[p]);
    assign pad_pull_dn_o[p] = dbg_own[p] ? dbg_pd[p] : (is_pulled[p] && !out_reg[p]);
    assign pad_in_en_o[p]   = dbg_own[p] || !is_analog[p];
    assign pad_speed_o[2*p +: 2] = dir;
  end

  assign pin_input_state_o  = lvl_reg & ~is_analog;
  // External line use needs input mode; software keeps pins there
  assign periph_in_o        = lvl_reg & ~is_out & ~is_analog & ~dbg_own;
  assign pin_output_value_o = out_reg;
  assign pin_config_low_o   = cfg_low_reg;
  assign pin_config_high_o  = cfg_high_reg;

  // ****************************************************************
  // Remap unit
  // ****************************************************************
  logic [PORT_N*PIN_N-1:0] all_levels;

  always_comb begin
    all_levels = other_port_level_i;
    all_levels[PIN_N*PORT_IDX +: PIN_N] = pin_input_state_o;
  end

  gpr_remap u_remap (
    .clk_i                (clk_i),
    .srst_i               (srst_i),
    .remap0_wr_i          (remap0_wr_i),
    .remap1_wr_i          (remap1_wr_i),
    .remap_wdata_i        (remap_wdata_i),
    .lss_wr_i             (lss_wr_i),
    .lss_wdata_i          (lss_wdata_i),
    .port_level_i         (all_levels),
    .remap_config_0_o     (remap_config_0_o),
    .remap_config_1_o     (remap_config_1_o),
    .line_source_select_o (line_source_select_o),
    .ext_line_o           (ext_line_o)
  );

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  property p_cfg_reset;
    $past(srst_i) |-> cfg_low_reg == CFG_RST && cfg_high_reg == CFG_RST && pad_oe_o == '0;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset)
    else $error("config not floating after reset");

  property p_bsc;
    bsc_wr_i && !out_wr_i && !bc_wr_i |=>
      out_reg == (($past(out_reg) & ~$past(bsc_wdata_i[31:16])) | $past(bsc_wdata_i[15:0]));
  endproperty
  a_bsc: assert property (p_bsc) else $error("set/clear write wrong");

  property p_frozen;
    (cfg_low_wr_i || cfg_high_wr_i) |=> ((cfg_all ^ $past(cfg_all)) & $past(slot_lock)) == '0;
  endproperty
  a_frozen: assert property (p_frozen) else $error("frozen slot changed");

  property p_analog;
    is_analog[0] |-> !pin_input_state_o[0] && !pad_oe_o[0] && !pad_pull_up_o[0];
  endproperty
  a_analog: assert property (p_analog) else $error("analog pin not idle");

  property p_pp;
    is_out[0] && !is_od[0] && !dbg_own[0] |-> pad_oe_o[0] && pad_out_o[0] == drv[0];
  endproperty
  a_pp: assert property (p_pp) else $error("push-pull drive wrong");

  property p_od;
    is_od[0] && !dbg_own[0] |-> !pad_out_o[0] && pad_oe_o[0] == !drv[0];
  endproperty
  a_od: assert property (p_od) else $error("open-drain drive wrong");

  property p_no_pull_out;
    ((pad_pull_up_o | pad_pull_dn_o) & is_out & ~dbg_own) == '0;
  endproperty
  a_no_pull_out: assert property (p_no_pull_out) else $error("pull on output pin");

  property p_sample;
    pad_in_i[0] [*4] |=> lvl_reg[0];
  endproperty
  a_sample: assert property (p_sample) else $error("pin level not sampled");

  property p_periph_drive;
    is_periph[0] && !dbg_own[0] && !is_od[0] |-> pad_out_o[0] == periph_out_i[0];
  endproperty
  a_periph_drive: assert property (p_periph_drive)
    else $error("peripheral not driving");

  c_periph_out: cover property (is_periph[0] && pad_oe_o[0]);
  c_frozen:     cover property (frozen_mask != '0 ##1 cfg_low_wr_i);
  c_bsc:        cover property (bsc_wr_i && bsc_wdata_i[15:0] != '0 && bsc_wdata_i[31:16] != '0);
  c_pulled:     cover property (is_pulled[0] && pad_pull_up_o[0]);

endmodule

// ### hw/gpr_remap.sv
// Remap unit: remap configuration and external line source selection
`timescale 1ns/1ps
module gpr_remap
  import gpr_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  srst_i,
  // Register writes
  input  wire logic                  remap0_wr_i,
  input  wire logic                  remap1_wr_i,
  input  wire logic [31:0]           remap_wdata_i,
  input  wire logic [3:0]            lss_wr_i,
  input  wire logic [15:0]           lss_wdata_i,
  // Sampled levels of all ports, port k at bits 16k+15:16k
  input  wire logic [PORT_N*PIN_N-1:0] port_level_i,
  // Results
  output logic      [31:0]           remap_config_0_o,
  output logic      [31:0]           remap_config_1_o,
  output logic      [63:0]           line_source_select_o,
  output logic      [PIN_N-1:0]      ext_line_o
);

  logic [31:0] r0_reg, r0_next, r1_reg, r1_next;
  logic [63:0] lss_reg, lss_next;

  always_comb begin
    r0_next  = remap0_wr_i ? remap_wdata_i : r0_reg;
    r1_next  = remap1_wr_i ? remap_wdata_i : r1_reg;
    lss_next = lss_reg;
    for (int k = 0; k < 4; k++) begin
      if (lss_wr_i[k]) begin
        lss_next[16*k +: 16] = lss_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      r0_reg  <= REMAP_RST;
      r1_reg  <= REMAP_RST;
      lss_reg <= LSS_RST;
    end else begin
      r0_reg  <= r0_next;
      r1_reg  <= r1_next;
      lss_reg <= lss_next;
    end
  end

  // Line x takes pin x of the selected port; codes past the last port read 0
  for (genvar x = 0; x < PIN_N; x++) begin : g_line
    logic [3:0] sel;
    assign sel = lss_reg[4*x +: 4];
    assign ext_line_o[x] = (sel < 4'(PORT_N)) ? port_level_i[PIN_N*sel + x]
                                              : 1'b0;
  end

  // Peripheral location tables live in each peripheral; they read these words
  assign remap_config_0_o     = r0_reg;
  assign remap_config_1_o     = r1_reg;
  assign line_source_select_o = lss_reg;

endmodule

// ### tb/gpr_pads_model.sv
// Board-side pad model: resolves each pin level from driver, pulls and board drive
`timescale 1ns/1ps
module gpr_pads_model (
  // Clock
  input  wire logic        clk_i,
  // Port pad controls
  input  wire logic [15:0] pad_out_i,
  input  wire logic [15:0] pad_oe_i,
  input  wire logic [15:0] pad_pull_up_i,
  input  wire logic [15:0] pad_pull_dn_i,
  // Board drive
  input  wire logic [15:0] ext_en_i,
  input  wire logic [15:0] ext_val_i,
  // Resolved level
  output logic      [15:0] pad_level_o
);
  logic flt_reg = 1'b0;

  // Undriven, unpulled pins wander so a missing pull never reads as a clean level
  always_ff @(posedge clk_i) begin
    flt_reg <= ~flt_reg;
  end

  // A released open-drain pin falls back to the board drive or the pulls
  always_comb begin
    pad_level_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_en_i & ext_val_i)
                | (~pad_oe_i & ~ext_en_i & (pad_pull_up_i | (~pad_pull_dn_i & {16{flt_reg}})));
  end
endmodule

// ### tb/gpr_port_tb.sv
// Self-checking bench for the general-purpose port
`timescale 1ns/1ps
module gpr_port_tb;
  import gpr_pkg::*;
  typedef struct packed {
    logic [1:0] fn;
    logic [1:0] dir;
    logic       ob, pb, oe, po, pu, pd, ie;
  } gpr_row_t;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic [11:0] stb = '0;
  logic [31:0] wd = '0;
  logic [79:0] olv = '0;
  logic [15:0] pin, pout, poe, ppu, ppd, pie, pfi, per = '0, ext_en = 16'h0001;
  logic [31:0] spd, cl, ch, rm0, rm1;
  logic [15:0] ov, ist, xl, bppu;
  logic [16:0] frz;
  logic [63:0] lss;
  logic [2:0]  rel [4] = '{3'h0, 3'h1, 3'h4, 3'h2};
  int          mismatches = 0;
  int          comparisons = 0;
  gpr_row_t    r;
  gpr_row_t    rows [11] = '{11'b00000000000, 11'b01001100001, 11'b10000000011,
                             11'b10001000101, 11'b00011011001, 11'b00110110001,
                             11'b01100010001, 11'b01011000001, 11'b10110111001,
                             11'b11101010001, 11'b11010100001};

  initial forever #12.5 clk_i = ~clk_i;

  gpr_port i_gpr_port (.clk_i(clk_i), .srst_i(srst_i), .cfg_low_wr_i(stb[0]),
    .cfg_high_wr_i(stb[1]), .cfg_wdata_i(wd), .out_wr_i(stb[2]), .out_wdata_i(wd[15:0]),
    .bsc_wr_i(stb[3]), .bsc_wdata_i(wd), .bc_wr_i(stb[4]), .bc_wdata_i(wd[15:0]),
    .freeze_wr_i(stb[5]), .freeze_wdata_i(wd[16:0]), .remap0_wr_i(stb[6]),
    .remap1_wr_i(stb[7]), .remap_wdata_i(wd), .lss_wr_i(stb[11:8]), .lss_wdata_i(wd[15:0]),
    .other_port_level_i(olv), .pad_in_i(pin), .pad_out_o(pout), .pad_oe_o(poe),
    .pad_pull_up_o(ppu), .pad_pull_dn_o(ppd), .pad_in_en_o(pie), .pad_speed_o(spd),
    .periph_out_i(per), .periph_in_o(pfi), .pin_config_low_o(cl), .pin_config_high_o(ch),
    .pin_output_value_o(ov), .pin_input_state_o(ist), .config_freeze_reg_o(frz),
    .remap_config_0_o(rm0), .remap_config_1_o(rm1), .line_source_select_o(lss),
    .ext_line_o(xl));

  gpr_pads_model i_gpr_pads_model (.clk_i(clk_i), .pad_out_i(pout), .pad_oe_i(poe),
    .pad_pull_up_i(ppu), .pad_pull_dn_i(ppd), .ext_en_i(ext_en), .ext_val_i(16'hffff),
    .pad_level_o(pin));

  // Second port carries the debug data-out and reset pins
  gpr_port #(.PORT_IDX(PORT_B)) i_gpr_port_b (.clk_i(clk_i), .srst_i(srst_i),
    .cfg_low_wr_i(stb[0]), .cfg_high_wr_i(stb[1]), .cfg_wdata_i(wd), .out_wr_i(stb[2]),
    .out_wdata_i(wd[15:0]), .bsc_wr_i(stb[3]), .bsc_wdata_i(wd), .bc_wr_i(stb[4]),
    .bc_wdata_i(wd[15:0]), .freeze_wr_i(stb[5]), .freeze_wdata_i(wd[16:0]),
    .remap0_wr_i(stb[6]), .remap1_wr_i(stb[7]), .remap_wdata_i(wd), .lss_wr_i(stb[11:8]),
    .lss_wdata_i(wd[15:0]), .other_port_level_i(olv), .pad_in_i(pin), .pad_out_o(),
    .pad_oe_o(), .pad_pull_up_o(bppu), .pad_pull_dn_o(), .pad_in_en_o(), .pad_speed_o(),
    .periph_out_i(per), .periph_in_o(), .pin_config_low_o(), .pin_config_high_o(),
    .pin_output_value_o(), .pin_input_state_o(), .config_freeze_reg_o(),
    .remap_config_0_o(), .remap_config_1_o(), .line_source_select_o(), .ext_line_o());

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic wr(input int k, input logic [31:0] d);
    @(negedge clk_i);
    stb = 12'h1 << k;
    wd = d;
    @(negedge clk_i);
    stb = '0;
  endtask

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk_reset();
    chk("cfg_low", 32'h4444_4444, cl);
    chk("cfg_high", 32'h4444_4444, ch);
    chk("oe", 16'h0, poe);
    chk("freeze", 1'b0, frz[16]);
    chk("pull_up", 16'ha000, ppu);
    chk("pull_dn", 16'h4000, ppd);
    chk("pull_up_b", 16'h0010, bppu);
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    report_and_stop();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(negedge clk_i);
    srst_i = 1'b0;
    chk_reset();
    foreach (rows[i]) begin
      r = rows[i];
      per = {15'h0, r.pb};
      wr(0, {28'h4444444, r.fn, r.dir});
      wr(2, {31'h0, r.ob});
      chk("oe", r.oe, poe[0]);
      if (r.oe) chk("out", r.po, pout[0]);
      chk("pull_up", r.pu, ppu[0]);
      chk("pull_dn", r.pd, ppd[0]);
      chk("in_en", r.ie, pie[0]);
      chk("speed", r.dir, spd[1:0]);
      chk("out_value", r.ob, ov[0]);
      repeat (5) @(negedge clk_i);
      chk("in_state", r.ie & (r.oe ? r.po : 1'b1), ist[0]);
      if (r.dir == 2'h0 && r.ie) chk("periph_in", 1'b1, pfi[0]);
    end
    wr(2, 32'h00f0);
    wr(3, 32'h0010_0003);
    chk("out_value", 16'h00e3, ov);
    wr(4, 32'h0080);
    chk("out_value", 16'h0063, ov);
    wr(0, 32'h4444_4444);
    wr(5, 32'h1_0001);
    wr(5, 32'h0_0001);
    wr(5, 32'h1_0001);
    chk("freeze", 1'b1, frz[16]);
    wr(0, 32'h0);
    chk("cfg_low", 32'h0000_0004, cl);
    foreach (rel[i]) begin
      wr(6, {5'h0, rel[i], 24'h0});
      chk("remap0", {5'h0, rel[i], 24'h0}, rm0);
      chk("pull_up", rel[i] != 3'h4, ppu[13]);
      chk("pull_dn", rel[i] != 3'h4, ppd[14]);
      chk("pull_up_b", rel[i] != 3'h1 && rel[i] != 3'h4, bppu[4]);
    end
    wr(7, 32'h0000_005a);
    chk("remap1", 32'h0000_005a, rm1);
    // Line 5 stays an input so it may serve as an external line
    olv[21] = 1'b1;
    wr(9, 32'h0010);
    chk("line_sel", 4'h1, lss[23:20]);
    chk("ext_line", 1'b1, xl[5]);
    olv[21] = 1'b0;
    #1;
    chk("ext_line", 1'b0, xl[5]);
    @(negedge clk_i);
    srst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    srst_i = 1'b0;
    chk_reset();
    report_and_stop();
  end
endmodule
